// file: src/rdp_buf.sv
// two-entry valid/ready buffer on the pixel path
`timescale 1ns/100ps
`default_nettype none
module rdp_buf #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rstN,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [PTR_W-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic             push, pop;

	assign inReady  = (cnt_ff != FULL_CNT);
	assign outValid = (cnt_ff != '0);
	assign outData  = mem_ff[rdPtr_ff];

	always_comb begin
		push      = inValid & inReady;
		pop       = outValid & outReady;
		nxt_mem   = mem_ff;
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_cnt   = cnt_ff;
		if (push) begin
			nxt_mem[wrPtr_ff] = inData;
			nxt_wrPtr = (wrPtr_ff == LAST_PTR) ? '0 : PTR_W'(wrPtr_ff + 1'b1);
		end
		if (pop) begin
			nxt_rdPtr = (rdPtr_ff == LAST_PTR) ? '0 : PTR_W'(rdPtr_ff + 1'b1);
		end
		if (push && !pop) begin
			nxt_cnt = CNT_W'(cnt_ff + 1'b1);
		end else if (pop && !push) begin
			nxt_cnt = CNT_W'(cnt_ff - 1'b1);
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_ff[i] <= '0;
			end
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			cnt_ff   <= '0;
		end else begin
			mem_ff   <= nxt_mem;
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			cnt_ff   <= nxt_cnt;
		end
	end
endmodule
`default_nettype wire

// file: src/rdp_pixel_host.sv
// pixel capture, colour mapping and strobe host port of the palette DAC front end
//
// Summary of operation
// RULE1: capture all pixel lines each pixel clock rise
// RULE2: sample blanking on that same pixel edge
// RULE3: true-colour pixels go straight to DAC channels
// RULE4: pseudocolour pixels index the colour lookup table
// RULE5: drive selected register while read strobe low
// RULE6: latch register select at strobe falling edge
// RULE7: reset clears every host register but the synthesizer settings to zero
// RULE8: reset loads synthesizer default frequency settings
// RULE9: select bits decode four register locations
// RULE10: blanking low forces blank level, ignores pixels
// RULE11: write data taken at write strobe rising edge
// RULE12: data bus released after read strobe rises
// RULE13: six-bit colour: top bits ignored, read zero
`timescale 1ns/100ps
`default_nettype none
module rdp_pixel_host
	import rdp_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     nrst,
	input  wire logic                     pixClk,
	input  wire logic [rdp_pkg::PIX_W-1:0]  pixIn,
	input  wire logic                     blankN,
	input  wire logic                     rdN,
	input  wire logic                     wrN,
	input  wire logic [rdp_pkg::SEL_W-1:0]  regSelect,
	input  wire logic [rdp_pkg::DATA_W-1:0] dataIn,
	output logic      [rdp_pkg::DATA_W-1:0] dataOut,
	output logic                          dataOe,
	output var rdp_pkg::rdp_dac_s         dacOut,
	output logic                          dacValid,
	input  wire logic                     dacReady,
	output logic      [rdp_pkg::FREQ_W-1:0] synthFreqA,
	output logic      [rdp_pkg::FREQ_W-1:0] synthFreqB
);
	import rdp_pkg::*;

	// component of a colour entry
	function automatic logic [COL_W-1:0] pickComp(input rdp_entry_t e, input rdp_comp_e c);
		case (c)
			COMP_RED: pickComp = e[3*COL_W-1:2*COL_W];
			COMP_GRN: pickComp = e[2*COL_W-1:COL_W];
			COMP_BLU: pickComp = e[COL_W-1:0];
			default:  pickComp = '0;
		endcase
	endfunction

	// six-bit entries are scaled to full DAC range
	function automatic logic [COL_W-1:0] scaleCol(input logic [COL_W-1:0] c, input logic wide);
		scaleCol = wide ? c : {c[5:0], c[5:4]};
	endfunction

	// ---------------- pixel clock domain ----------------
	rdp_pix_s pixCap_ff, nxt_pixCap;
	logic     pixTgl_ff, nxt_pixTgl;

	always_comb begin
		nxt_pixCap = '{blankN: blankN, pix: pixIn}; // [RULE1] [RULE2]
		nxt_pixTgl = ~pixTgl_ff;
	end

	always_ff @(posedge pixClk or negedge nrst) begin
		if (!nrst) begin
			pixCap_ff <= '0;
			pixTgl_ff <= 1'b0;
		end else begin
			pixCap_ff <= nxt_pixCap;
			pixTgl_ff <= nxt_pixTgl;
		end
	end

	// ---------------- crossings into sys_clk ----------------
	// captured word is held a full pixel period, sampled three cycles after its toggle
	logic      tglA_ff, tglB_ff, tglC_ff;
	rdp_host_s hostA_ff, hostB_ff, hostC_ff;
	rdp_pix_s  pixXfer_ff, nxt_pixXfer;
	logic      pixEvent, pixEvent_ff;

	assign pixEvent = tglB_ff ^ tglC_ff;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tglA_ff  <= 1'b0;
			tglB_ff  <= 1'b0;
			tglC_ff  <= 1'b0;
			hostA_ff <= '{rdN: 1'b1, wrN: 1'b1, default: '0};
			hostB_ff <= '{rdN: 1'b1, wrN: 1'b1, default: '0};
			hostC_ff <= '{rdN: 1'b1, wrN: 1'b1, default: '0};
		end else begin
			tglA_ff  <= pixTgl_ff;
			tglB_ff  <= tglA_ff;
			tglC_ff  <= tglB_ff;
			hostA_ff <= '{rdN: rdN, wrN: wrN, sel: regSelect, data: dataIn};
			hostB_ff <= hostA_ff;
			hostC_ff <= hostB_ff;
		end
	end

	// ---------------- host register port ----------------
	logic [SEL_W-1:0]  sel_ff, nxt_sel;
	logic [IDX_W-1:0]  addr_ff, nxt_addr;
	logic [DATA_W-1:0] mask_ff, nxt_mask;
	logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
	logic              ovr_ff, nxt_ovr;
	rdp_comp_e         wrComp_ff, nxt_wrComp, rdComp_ff, nxt_rdComp;
	logic [COL_W-1:0]  stgRed_ff, nxt_stgRed, stgGrn_ff, nxt_stgGrn;
	rdp_entry_t        lut_ff [LUT_DEPTH];
	rdp_entry_t        nxt_lut [LUT_DEPTH];
	logic [DATA_W-1:0] dout_ff, nxt_dout;
	logic              oe_ff, nxt_oe;
	logic              rdFall, rdRise, wrFall, wrRise, wide, bufInReady;
	logic [DATA_W-1:0] wCol, rdVal;

	always_comb begin
		rdFall     = hostC_ff.rdN & ~hostB_ff.rdN;
		rdRise     = ~hostC_ff.rdN & hostB_ff.rdN;
		wrFall     = hostC_ff.wrN & ~hostB_ff.wrN;
		wrRise     = ~hostC_ff.wrN & hostB_ff.wrN;
		wide       = ctrl_ff[CTRL_WIDE_BIT];
		wCol       = wide ? hostB_ff.data : (hostB_ff.data & COL6_MASK); // [RULE13]
		nxt_sel    = sel_ff;
		nxt_addr   = addr_ff;
		nxt_mask   = mask_ff;
		nxt_ctrl   = ctrl_ff;
		nxt_ovr    = ovr_ff;
		nxt_wrComp = wrComp_ff;
		nxt_rdComp = rdComp_ff;
		nxt_stgRed = stgRed_ff;
		nxt_stgGrn = stgGrn_ff;
		nxt_lut    = lut_ff;
		nxt_dout   = dout_ff;
		nxt_oe     = ~hostB_ff.rdN; // [RULE5] [RULE12]

		if (rdFall || wrFall) begin
			nxt_sel = hostB_ff.sel; // [RULE6]
		end

		// read value chosen from the select seen at the falling edge
		case (hostB_ff.sel) // [RULE9]
			SEL_ADDR: rdVal = addr_ff;
			SEL_PAL:  rdVal = pickComp(lut_ff[addr_ff], rdComp_ff);
			SEL_MASK: rdVal = mask_ff;
			SEL_CTRL: rdVal = {ovr_ff, ctrl_ff[CTRL_OVR_BIT-1:0]};
			default:  rdVal = '0;
		endcase
		if (hostB_ff.sel == SEL_PAL && !wide) begin
			rdVal = rdVal & COL6_MASK; // [RULE13]
		end
		if (rdFall) begin
			nxt_dout = rdVal; // [RULE5]
		end

		// palette read walks red, green, blue then steps the index
		if (rdRise && sel_ff == SEL_PAL) begin
			case (rdComp_ff)
				COMP_RED: nxt_rdComp = COMP_GRN;
				COMP_GRN: nxt_rdComp = COMP_BLU;
				default: begin
					nxt_rdComp = COMP_RED;
					nxt_addr   = IDX_W'(addr_ff + IDX_STEP);
				end
			endcase
		end

		if (wrRise) begin
			case (sel_ff) // [RULE9] [RULE11]
				SEL_ADDR: begin
					nxt_addr   = hostB_ff.data;
					nxt_wrComp = COMP_RED;
					nxt_rdComp = COMP_RED;
				end
				SEL_PAL: begin
					case (wrComp_ff)
						COMP_RED: begin
							nxt_stgRed = wCol;
							nxt_wrComp = COMP_GRN;
						end
						COMP_GRN: begin
							nxt_stgGrn = wCol;
							nxt_wrComp = COMP_BLU;
						end
						default: begin
							nxt_lut[addr_ff] = {stgRed_ff, stgGrn_ff, wCol};
							nxt_addr         = IDX_W'(addr_ff + IDX_STEP);
							nxt_wrComp       = COMP_RED;
						end
					endcase
				end
				SEL_MASK: nxt_mask = hostB_ff.data;
				SEL_CTRL: begin
					nxt_ctrl = hostB_ff.data & CTRL_WR_MASK;
					if (hostB_ff.data[CTRL_OVR_BIT]) begin
						nxt_ovr = 1'b0;
					end
				end
				default: nxt_mask = mask_ff;
			endcase
		end

		// a lost word wins over a clear in the same cycle
		if (pixEvent_ff && !bufInReady) begin
			nxt_ovr = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sel_ff    <= '0;
			addr_ff   <= REG_RESET; // [RULE7]
			mask_ff   <= REG_RESET;
			ctrl_ff   <= REG_RESET;
			ovr_ff    <= 1'b0;
			wrComp_ff <= COMP_RED;
			rdComp_ff <= COMP_RED;
			stgRed_ff <= REG_RESET;
			stgGrn_ff <= REG_RESET;
			for (int i = 0; i < LUT_DEPTH; i++) begin
				lut_ff[i] <= '0;
			end
			dout_ff   <= REG_RESET;
			oe_ff     <= 1'b0;
		end else begin
			sel_ff    <= nxt_sel;
			addr_ff   <= nxt_addr;
			mask_ff   <= nxt_mask;
			ctrl_ff   <= nxt_ctrl;
			ovr_ff    <= nxt_ovr;
			wrComp_ff <= nxt_wrComp;
			rdComp_ff <= nxt_rdComp;
			stgRed_ff <= nxt_stgRed;
			stgGrn_ff <= nxt_stgGrn;
			lut_ff    <= nxt_lut;
			dout_ff   <= nxt_dout;
			oe_ff     <= nxt_oe;
		end
	end

	assign dataOut = dout_ff;
	assign dataOe  = oe_ff;

	// synthesizer settings: no write path here, defaults held from reset
	logic [FREQ_W-1:0] synA_ff, synB_ff;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			synA_ff <= SYNTH_A_KHZ; // [RULE8]
			synB_ff <= SYNTH_B_KHZ; // [RULE8]
		end else begin
			synA_ff <= synA_ff;
			synB_ff <= synB_ff;
		end
	end

	assign synthFreqA = synA_ff;
	assign synthFreqB = synB_ff;

	// ---------------- pixel path in sys_clk ----------------
	rdp_pix_s   bufOut;
	logic       bufOutValid, bufOutReady;
	rdp_dac_s   dac_ff, nxt_dac;
	logic       dacValid_ff, nxt_dacValid;
	rdp_entry_t entry;

	rdp_buf #(
		.WIDTH ($bits(rdp_pix_s)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk      (sys_clk),
		.rstN     (nrst),
		.inValid  (pixEvent_ff),
		.inReady  (bufInReady),
		.inData   (pixXfer_ff),
		.outValid (bufOutValid),
		.outReady (bufOutReady),
		.outData  (bufOut)
	);

	always_comb begin
		nxt_pixXfer  = pixEvent ? pixCap_ff : pixXfer_ff;
		bufOutReady  = ~dacValid_ff | dacReady;
		nxt_dac      = dac_ff;
		nxt_dacValid = dacValid_ff & ~dacReady;
		entry        = lut_ff[bufOut.pix[IDX_W-1:0] & mask_ff]; // [RULE4]
		if (bufOutValid && bufOutReady) begin
			nxt_dacValid = 1'b1;
			if (!bufOut.blankN) begin
				nxt_dac = '{blank: 1'b1, default: '0}; // [RULE10]
			end else if (ctrl_ff[CTRL_TRUE_BIT]) begin
				nxt_dac.blank = 1'b0; // [RULE3]
				nxt_dac.red   = {bufOut.pix[RED_HI:RED_LO], bufOut.pix[RED_HI:RED_HI-2]};
				nxt_dac.green = {bufOut.pix[GRN_HI:GRN_LO], bufOut.pix[GRN_HI:GRN_HI-1]};
				nxt_dac.blue  = {bufOut.pix[BLU_HI:BLU_LO], bufOut.pix[BLU_HI:BLU_HI-2]};
			end else begin
				nxt_dac.blank = 1'b0; // [RULE4]
				nxt_dac.red   = scaleCol(pickComp(entry, COMP_RED), wide);
				nxt_dac.green = scaleCol(pickComp(entry, COMP_GRN), wide);
				nxt_dac.blue  = scaleCol(pickComp(entry, COMP_BLU), wide);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pixXfer_ff  <= '0;
			pixEvent_ff <= 1'b0;
			dac_ff      <= '0;
			dacValid_ff <= 1'b0;
		end else begin
			pixXfer_ff  <= nxt_pixXfer;
			pixEvent_ff <= pixEvent;
			dac_ff      <= nxt_dac;
			dacValid_ff <= nxt_dacValid;
		end
	end

	assign dacOut   = dac_ff;
	assign dacValid = dacValid_ff;
endmodule
`default_nettype wire

// file: src/rdp_pkg.sv
// shared constants and types of the pixel and host port block
package rdp_pkg;
	localparam int PIX_W     = 16;
	localparam int SEL_W     = 2;
	localparam int DATA_W    = 8;
	localparam int COL_W     = 8;
	localparam int IDX_W     = 8;
	localparam int LUT_DEPTH = 256;
	localparam int BUF_DEPTH = 2;
	localparam int FREQ_W    = 16;

	// four directly addressed host locations
	localparam logic [SEL_W-1:0] SEL_ADDR = 2'h0;
	localparam logic [SEL_W-1:0] SEL_PAL  = 2'h1;
	localparam logic [SEL_W-1:0] SEL_MASK = 2'h2;
	localparam logic [SEL_W-1:0] SEL_CTRL = 2'h3;

	localparam int CTRL_TRUE_BIT = 0;
	localparam int CTRL_WIDE_BIT = 1;
	localparam int CTRL_OVR_BIT  = 7;
	localparam logic [DATA_W-1:0] CTRL_WR_MASK = 8'h03;
	localparam logic [DATA_W-1:0] REG_RESET    = 8'h00;
	localparam logic [DATA_W-1:0] COL6_MASK    = 8'h3F;
	localparam logic [IDX_W-1:0]  IDX_STEP     = 8'h01;

	// synthesizer defaults in kHz: 28.322 MHz and 25.175 MHz
	localparam logic [FREQ_W-1:0] SYNTH_A_KHZ = 16'h6EA2;
	localparam logic [FREQ_W-1:0] SYNTH_B_KHZ = 16'h6257;

	// 5:6:5 true-colour field positions
	localparam int RED_HI = 15;
	localparam int RED_LO = 11;
	localparam int GRN_HI = 10;
	localparam int GRN_LO = 5;
	localparam int BLU_HI = 4;
	localparam int BLU_LO = 0;

	typedef logic [3*COL_W-1:0] rdp_entry_t;

	typedef struct packed {
		logic              rdN;
		logic              wrN;
		logic [SEL_W-1:0]  sel;
		logic [DATA_W-1:0] data;
	} rdp_host_s;

	typedef struct packed {
		logic             blankN;
		logic [PIX_W-1:0] pix;
	} rdp_pix_s;

	typedef struct packed {
		logic             blank;
		logic [COL_W-1:0] red;
		logic [COL_W-1:0] green;
		logic [COL_W-1:0] blue;
	} rdp_dac_s;

	typedef enum logic [2:0] {
		COMP_RED = 3'b001,
		COMP_GRN = 3'b010,
		COMP_BLU = 3'b100
	} rdp_comp_e;
endpackage

// file: tb/rdp_gfx_model.sv
// pixel source standing in for the graphics controller
`timescale 1ns/100ps
`default_nettype none
module rdp_gfx_model
	import rdp_pkg::*;
(
	output logic                       pixClk,
	output logic [rdp_pkg::PIX_W-1:0]  pixIn,
	output logic                       blankN
);
	initial begin
		pixClk = 1'b0;
		pixIn = 16'h0000;
		blankN = 1'b1;
	end
	// one 48 ns period; word set half a period before the rise
	task automatic send(input logic [rdp_pkg::PIX_W-1:0] p, input logic b);
		pixIn = p;
		blankN = b;
		#24 pixClk = 1'b1;
		#24 pixClk = 1'b0;
	endtask
	// clock stands between frames and the lines stop holding the word
	task automatic idle();
		#24 pixIn = ~pixIn;
	endtask
endmodule
`default_nettype wire

// file: tb/rdp_pixel_host_assertions.sv
// port checker of the pixel and host port block
`timescale 1ns/100ps
`default_nettype none
module rdp_pixel_host_chk
	import rdp_pkg::*;
(
	input wire logic                        sys_clk,
	input wire logic                        nrst,
	input wire logic                        rdN,
	input wire logic [rdp_pkg::DATA_W-1:0]  dataOut,
	input wire logic                        dataOe,
	input wire rdp_pkg::rdp_dac_s           dacOut,
	input wire logic                        dacValid,
	input wire logic                        dacReady,
	input wire logic [rdp_pkg::FREQ_W-1:0]  synthFreqA,
	input wire logic [rdp_pkg::FREQ_W-1:0]  synthFreqB
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// strobe is synced, so the bus answers a few cycles late
	sequence rdStart;
		$fell(rdN);
	endsequence
	sequence rdEnd;
		$rose(rdN);
	endsequence
	chk_synth_defaults: assert property (synthFreqA == SYNTH_A_KHZ && synthFreqB == SYNTH_B_KHZ)
		else $error("synth defaults changed");
	chk_read_drive: assert property (rdStart |-> ##[2:4] dataOe)
		else $error("bus not driven after read strobe");
	chk_read_release: assert property (rdEnd |-> ##[2:4] !dataOe)
		else $error("bus not released after read");
	chk_read_held: assert property ((!rdN) [*5] |-> dataOe)
		else $error("bus dropped during read");
	chk_idle_quiet: assert property (rdN [*6] |-> !dataOe)
		else $error("bus driven with no read");
	chk_read_stable: assert property (dataOe && $past(dataOe) |-> $stable(dataOut))
		else $error("read data moved while driven");
	chk_dac_stall: assert property (dacValid && !dacReady |=> dacValid && $stable(dacOut))
		else $error("pixel word lost under stall");
	chk_blank_black: assert property (dacValid && dacOut.blank |-> {dacOut.red, dacOut.green, dacOut.blue} == '0)
		else $error("blanked word carries colour");
endmodule
bind rdp_pixel_host rdp_pixel_host_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .rdN(rdN),
	.dataOut(dataOut), .dataOe(dataOe), .dacOut(dacOut), .dacValid(dacValid),
	.dacReady(dacReady), .synthFreqA(synthFreqA), .synthFreqB(synthFreqB));
`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the pixel and host port block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import rdp_pkg::*;
	logic              sys_clk, nrst, pixClk, blankN, rdN, wrN, dataOe, dacValid, dacReady;
	logic [PIX_W-1:0]  pixIn;
	logic [SEL_W-1:0]  regSelect;
	logic [DATA_W-1:0] dataIn, dataOut;
	logic [FREQ_W-1:0] synthFreqA, synthFreqB;
	rdp_dac_s          dacOut;
	rdp_dac_s          got[$];
	int                nMismatch = 0;
	int                checkCount = 0;

	rdp_gfx_model u_gfx (.pixClk(pixClk), .pixIn(pixIn), .blankN(blankN));
	rdp_pixel_host u_dut (.sys_clk(sys_clk), .nrst(nrst), .pixClk(pixClk), .pixIn(pixIn),
		.blankN(blankN), .rdN(rdN), .wrN(wrN), .regSelect(regSelect), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .dacOut(dacOut), .dacValid(dacValid),
		.dacReady(dacReady), .synthFreqA(synthFreqA), .synthFreqB(synthFreqB));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (dacValid === 1'b1 && dacReady === 1'b1) got.push_back(dacOut);
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			nMismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checkCount, nMismatch);
		if (nMismatch == 0 && checkCount > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// strobe edges spaced well past the two-stage sync
	task automatic hwr(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] d);
		regSelect <= s;
		dataIn <= d;
		@(posedge sys_clk);
		wrN <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wrN <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// host lets go of the bus once its hold time is over
		dataIn <= ~d;
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic rdchk(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] exp);
		regSelect <= s;
		@(posedge sys_clk);
		rdN <= 1'b0;
		repeat (5) @(posedge sys_clk);
		check("read data", dataOut, exp);
		check("bus driven", dataOe, 1'b1);
		rdN <= 1'b1;
		repeat (5) @(posedge sys_clk);
		check("bus released", dataOe, 1'b0);
	endtask
	task automatic wait_words(input int n);
		repeat (200) if (got.size() < n) @(posedge sys_clk);
		check("word count", got.size() >= n, 1'b1);
	endtask
	function automatic rdp_dac_s tc(input logic [PIX_W-1:0] p);
		return '{1'b0, {p[15:11], p[15:13]}, {p[10:5], p[10:9]}, {p[4:0], p[4:2]}};
	endfunction

	task automatic t_reset();
		check("synth a", synthFreqA, 16'h6EA2);
		check("synth b", synthFreqB, 16'h6257);
		check("dac idle", dacValid, 1'b0);
		rdchk(SEL_CTRL, 8'h00);
		rdchk(SEL_MASK, 8'h00);
		rdchk(SEL_ADDR, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_regs();
		hwr(SEL_MASK, 8'hA5);
		hwr(SEL_ADDR, 8'h12);
		rdchk(SEL_MASK, 8'hA5);
		rdchk(SEL_ADDR, 8'h12);
		hwr(SEL_CTRL, 8'hFF);
		rdchk(SEL_CTRL, 8'h03);
		hwr(SEL_CTRL, 8'h00);
		$display("test registers done");
	endtask
	task automatic t_pseudo();
		hwr(SEL_ADDR, 8'h05);
		hwr(SEL_PAL, 8'hFF);
		hwr(SEL_PAL, 8'h81);
		hwr(SEL_PAL, 8'h2A);
		hwr(SEL_ADDR, 8'h05);
		rdchk(SEL_PAL, 8'h3F);
		rdchk(SEL_PAL, 8'h01);
		rdchk(SEL_PAL, 8'h2A);
		hwr(SEL_MASK, 8'h0F);
		got.delete();
		u_gfx.send(16'h00F5, 1'b1);
		u_gfx.send(16'h00F5, 1'b0);
		u_gfx.send(16'h0005, 1'b1);
		u_gfx.idle();
		wait_words(3);
		// six-bit entries widen by repeating their top bits
		check("lookup", got[0], {1'b0, 8'hFF, 8'h04, 8'hAA});
		check("blanked", got[1], {1'b1, 24'h0});
		check("unblank", got[2], {1'b0, 8'hFF, 8'h04, 8'hAA});
		$display("test pseudocolour done");
	endtask
	task automatic t_wide();
		hwr(SEL_CTRL, 8'h02);
		hwr(SEL_ADDR, 8'h07);
		hwr(SEL_PAL, 8'hC3);
		hwr(SEL_PAL, 8'h81);
		hwr(SEL_PAL, 8'h2A);
		hwr(SEL_ADDR, 8'h07);
		rdchk(SEL_PAL, 8'hC3);
		got.delete();
		// mask is still 0F, so 17 selects entry 07
		u_gfx.send(16'h0017, 1'b1);
		u_gfx.idle();
		wait_words(1);
		check("wide lookup", got[0], {1'b0, 8'hC3, 8'h81, 8'h2A});
		hwr(SEL_CTRL, 8'h00);
		// green was stored with its top bit set; six-bit read must hide it
		rdchk(SEL_PAL, 8'h01);
		$display("test eight-bit done");
	endtask
	task automatic t_true();
		logic [PIX_W-1:0] pv[3] = '{16'hF81F, 16'h07E0, 16'h8410};
		hwr(SEL_CTRL, 8'h01);
		got.delete();
		foreach (pv[i]) u_gfx.send(pv[i], 1'b1);
		u_gfx.idle();
		wait_words(3);
		foreach (pv[i]) check("true colour", got[i], tc(pv[i]));
		$display("test true colour done");
	endtask
	task automatic t_stall();
		dacReady <= 1'b0;
		got.delete();
		for (int i = 0; i < 6; i++) u_gfx.send(16'h1000 + 16'(i), 1'b1);
		u_gfx.idle();
		rdchk(SEL_CTRL, 8'h81);
		hwr(SEL_CTRL, 8'h81);
		rdchk(SEL_CTRL, 8'h01);
		dacReady <= 1'b1;
		wait_words(3);
		repeat (20) @(posedge sys_clk);
		check("held count", got.size(), 32'd3);
		foreach (got[i]) check("held word", got[i], tc(16'h1000 + 16'(i)));
		check("drained", dacValid, 1'b0);
		$display("test stall done");
	endtask

	initial begin
		#100000;
		nMismatch++;
		give_verdict();
	end
	initial begin
		nrst = 1'b0;
		rdN = 1'b1;
		wrN = 1'b1;
		regSelect = 2'h0;
		dataIn = 8'h00;
		dacReady = 1'b1;
		// two pixel edges must land inside reset as well
		u_gfx.send(16'h0000, 1'b1);
		u_gfx.send(16'h0000, 1'b1);
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_regs();
		t_pseudo();
		t_wide();
		t_true();
		t_stall();
		give_verdict();
	end
endmodule
`default_nettype wire
